// ### wei_defs.vh
// Purpose: Constants for the wake event indicator and ready flag block
// Assumes: 100 MHz device clock, 32-bit register port
// Notes:   Offsets are byte addresses on the plain register port
`ifndef WEI_DEFS_VH
`define WEI_DEFS_VH

`define WEI_ADDR_W          8
`define WEI_OFS_PMC         8'h84
`define WEI_OFS_HWCFG       8'h74
`define WEI_BIT_READY       0
`define WEI_BIT_OUT_EN      1
`define WEI_BIT_POL         2
`define WEI_BIT_PULSE       3
`define WEI_CAUSE_LO        4
`define WEI_CAUSE_HI        5
`define WEI_BIT_DRIVE       6
`define WEI_BIT_ENERGY_WAKE_ENABLE       8
`define WEI_BIT_NET_EN      9
`define WEI_MODE_LO         12
`define WEI_MODE_HI         13
`define WEI_CAUSE_NONE      2'h0
`define WEI_CAUSE_ENERGY    2'h1
`define WEI_CAUSE_NET       2'h2
`define WEI_CAUSE_MULTI     2'h3
`define WEI_MODE_NORMAL     2'h0
`define WEI_MODE_NET        2'h1
`define WEI_MODE_ENERGY     2'h2
`define WEI_PULSE_MS        50
`define WEI_CLK_MHZ         100
`define WEI_PULSE_CYCLES    (`WEI_PULSE_MS * 1000 * `WEI_CLK_MHZ)
`define WEI_SETTLE_CYCLES   256

`endif

// ### wei_wake_ctrl.v
// Purpose: Wake cause status, external wake output and ready flag
// Assumes: Host accesses are single-cycle strobes; event inputs are pulses
// Notes:   Only the low control bits plus mode and enables are held here
//
// The address map and strobed register access were chosen for this implementation.

// Macros must exist before the parameter defaults use them
`include "wei_defs.vh"

module wei_wake_ctrl #(
    parameter PULSE_CYCLES  = `WEI_PULSE_CYCLES,
    parameter SETTLE_CYCLES = `WEI_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // Event sources, pulses, and their pending levels
    input  wire        net_event,
    input  wire        energy_event,
    input  wire        net_pending,
    input  wire        energy_pending,
    // Hardware configuration word supplied by the rest of the device
    input  wire [31:0] hardware_config_reg,
    // Wake indications
    output wire        wake_event_out_o,
    output wire        wake_event_out_oe,
    output wire        wake_irq_status,
    output wire [1:0]  power_mode_select,
    output wire        device_ready
);

    localparam ST_SETTLE = 1'b0;
    localparam ST_READY  = 1'b1;

    reg        state;
    reg [8:0]  settle_cnt;
    reg [1:0]  wake_cause;
    reg        wake_out_pulse_mode;
    reg        wake_out_polarity;
    reg        wake_out_enable;
    reg        wake_out_drive_type;
    reg        energy_wake_enable;
    reg        net_wake_enable;
    reg [1:0]  mode;
    reg        wake_active;
    reg [31:0] pulse_cnt;

    wire pmc_hit   = (addr == `WEI_OFS_PMC);
    wire pmc_wr    = wr && pmc_hit;
    wire net_hit   = net_event && net_wake_enable;
    wire en_hit    = energy_event && energy_wake_enable;
    wire any_event = net_hit || en_hit;
    wire clr_ok    = pmc_wr && (state == ST_READY);
    wire clr_net   = clr_ok && wdata[`WEI_CAUSE_HI] && !net_pending;
    wire clr_en    = clr_ok && wdata[`WEI_CAUSE_LO] && !energy_pending;
    // Bit order gives 01 energy, 10 net, 11 both
    wire [1:0] next_cause = {net_hit || (wake_cause[1] && !clr_net),
                             en_hit || (wake_cause[0] && !clr_en)};
    wire src_live  = (next_cause[1] && net_wake_enable) || (next_cause[0] && energy_wake_enable);

    assign device_ready      = (state == ST_READY);
    assign power_mode_select = mode;
    assign wake_irq_status   = wake_cause != `WEI_CAUSE_NONE;

    // Output active level; open-drain forces active low and drives only low
    wire asserted = wake_active && wake_out_enable;
    assign wake_event_out_o  = wake_out_drive_type ?
                               (asserted ~^ wake_out_polarity) : 1'b0;
    assign wake_event_out_oe = wake_out_drive_type ? 1'b1 : asserted;

    // Ready after settling; leaving normal mode drops it again
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_SETTLE;
            settle_cnt <= 9'h000;
        end else begin
            case (state)
                ST_SETTLE: begin
                    if (mode == `WEI_MODE_NORMAL && settle_cnt == SETTLE_CYCLES - 1) begin
                        state <= ST_READY;
                    end else if (mode == `WEI_MODE_NORMAL) begin
                        settle_cnt <= settle_cnt + 9'h001;
                    end
                end
                ST_READY: begin
                    if (mode != `WEI_MODE_NORMAL) begin
                        state      <= ST_SETTLE;
                        settle_cnt <= 9'h000;
                    end
                end
                default: state <= ST_SETTLE;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cause          <= `WEI_CAUSE_NONE;
            wake_out_pulse_mode <= 1'b0;
            wake_out_polarity   <= 1'b0;
            wake_out_enable     <= 1'b0;
            wake_out_drive_type <= 1'b0;
            energy_wake_enable  <= 1'b0;
            net_wake_enable     <= 1'b0;
            mode                <= `WEI_MODE_NORMAL;
        end else begin
            wake_cause <= next_cause;
            if (pmc_wr) begin
                wake_out_pulse_mode <= wdata[`WEI_BIT_PULSE];
                wake_out_polarity   <= wdata[`WEI_BIT_POL];
                wake_out_enable     <= wdata[`WEI_BIT_OUT_EN];
                wake_out_drive_type <= wdata[`WEI_BIT_DRIVE];
                energy_wake_enable  <= wdata[`WEI_BIT_ENERGY_WAKE_ENABLE];
                net_wake_enable     <= wdata[`WEI_BIT_NET_EN];
                if (wdata[`WEI_MODE_HI:`WEI_MODE_LO] != 2'h3) begin
                    mode <= wdata[`WEI_MODE_HI:`WEI_MODE_LO];
                end
            end else if (any_event && mode != `WEI_MODE_NORMAL) begin
                // Wake event brings the device back to normal mode
                mode <= `WEI_MODE_NORMAL;
            end
        end
    end

    // Wake output hold and pulse timer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_active <= 1'b0;
            pulse_cnt   <= 32'h0000_0000;
        end else if (any_event) begin
            wake_active <= 1'b1;
            pulse_cnt   <= 32'h0000_0000;
        end else if (!src_live) begin
            wake_active <= 1'b0;
            pulse_cnt   <= 32'h0000_0000;
        end else if (wake_active && wake_out_pulse_mode) begin
            if (pulse_cnt == PULSE_CYCLES - 1) begin
                wake_active <= 1'b0;
            end else begin
                pulse_cnt <= pulse_cnt + 32'h0000_0001;
            end
        end
    end

    // Readable in any mode; the PMC offset returns the control and status word, the HWCFG offset returns hardware_config_reg, other addresses read zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd && pmc_hit) begin
            rdata <= {18'h00000, mode, 2'h0, net_wake_enable, energy_wake_enable,
                      1'b0, wake_out_drive_type, wake_cause, wake_out_pulse_mode,
                      wake_out_polarity, wake_out_enable, device_ready};
        end else if (rd && addr == `WEI_OFS_HWCFG) begin
            rdata <= hardware_config_reg;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule // wei_wake_ctrl

// ### wei_wake_ctrl_sva.sv
// Purpose: Port-level checks of the wake control block
// Assumes: One clock domain, rst_n asynchronous active low
// Notes:   Register reads land one cycle after the strobe
module wei_wake_ctrl_sva (
    // Clock and reset
    input wire        clk, rst_n,
    // Register port
    input wire [7:0]  addr,
    input wire [31:0] wdata, rdata, hardware_config_reg,
    input wire        wr, rd, net_pending, energy_pending,
    // Status
    input wire        wake_irq_status, device_ready,
    input wire [1:0]  power_mode_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire pmc_rd = rd && addr == 8'h84;
    wire pmc_wr = wr && addr == 8'h84;
    property p_idle; !rd |=> rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("rdata not zero");
    property p_rdy; pmc_rd |=> rdata[0] == $past(device_ready); endproperty
    a_rdy: assert property (p_rdy) else $error("ready readback");
    property p_mode; pmc_rd |=> rdata[13:12] == $past(power_mode_select); endproperty
    a_mode: assert property (p_mode) else $error("mode readback");
    property p_irq; pmc_rd |=> (|rdata[5:4]) == $past(wake_irq_status); endproperty
    a_irq: assert property (p_irq) else $error("cause vs irq");
    property p_cfg; rd && addr == 8'h74 |=> rdata == $past(hardware_config_reg); endproperty
    a_cfg: assert property (p_cfg) else $error("config readback");
    property p_early; pmc_wr && !device_ready && wake_irq_status |=> wake_irq_status; endproperty
    a_early: assert property (p_early) else $error("clear before ready");
    property p_pend; pmc_wr && net_pending && energy_pending && wake_irq_status
        |=> wake_irq_status; endproperty
    a_pend: assert property (p_pend) else $error("clear while pending");
    property p_fell; $fell(wake_irq_status) |-> $past(pmc_wr) && $past(wdata[5:4]) != 2'h0;
    endproperty
    a_fell: assert property (p_fell) else $error("cause fell unasked");
    // Mode lands one edge after the write, ready drops on the edge after that
    property p_sleep; pmc_wr && wdata[13:12] == 2'h1 |-> ##2 !device_ready; endproperty
    a_sleep: assert property (p_sleep) else $error("ready kept in sleep");
    c_clear: cover property (wake_irq_status ##1 !wake_irq_status);
    c_ready: cover property ($rose(device_ready));
    c_early: cover property (pmc_rd && !device_ready);
endmodule // wei_wake_ctrl_sva

bind wei_wake_ctrl wei_wake_ctrl_sva i_wei_wake_ctrl_sva (.*);

// ### wei_wake_sink.sv
// Purpose: System wake input seen from the board
// Assumes: Pull-up on the wake net
// Notes:   Released net reads high, as the wired-OR line does
module wei_wake_sink (
    input  wire logic o, oe,
    output wire logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    assign line = oe ? o : 1'b1;
endmodule // wei_wake_sink

// ### wei_wake_ctrl_tb_top.sv
// Purpose: Self-checking bench for the wake control block
// Assumes: Short pulse and settle counts
// Notes:   Read expectations are queued and checked by a monitor
module wei_wake_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, net_event = 0, energy_event = 0;
    logic net_pending = 0, energy_pending = 0, rd_q = 0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, cfg = 32'h0, seed = 32'h17b7;
    wire [31:0] rdata;
    wire o, oe, irq, rdy, line;
    wire [1:0] mode;
    int n_fail = 0, cmp_count = 0;
    logic [31:0] q[$];
    always #5 clk = ~clk;
    wei_wake_ctrl #(.PULSE_CYCLES(20), .SETTLE_CYCLES(4)) i_wei_wake_ctrl (.clk(clk),
        .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .net_event(net_event), .energy_event(energy_event), .net_pending(net_pending),
        .energy_pending(energy_pending), .hardware_config_reg(cfg), .wake_event_out_o(o),
        .wake_event_out_oe(oe), .wake_irq_status(irq), .power_mode_select(mode),
        .device_ready(rdy));
    wei_wake_sink i_wei_wake_sink (.o(o), .oe(oe), .line(line));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task wrap_up;
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One bus cycle, optionally with event pulses beside it; d is the expectation of a read
    task op(input logic w, r, input logic [7:0] a, input logic [31:0] d, input logic n, e);
        @(posedge clk);
        {wr, rd, addr, wdata, net_event, energy_event} <= {w, r, a, d, n, e};
        if (r) q.push_back(d);
        @(posedge clk);
        {wr, rd, net_event, energy_event} <= 4'h0;
        #1;
    endtask
    task wait_rdy;
        for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
        if (rdy !== 1'b1) begin
            n_fail++;
            wrap_up;
        end
    endtask
    always @(posedge clk) begin
        if (rd_q) chk("rdata", q.pop_front(), rdata);
        rd_q <= rd;
    end
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
    initial begin
        cfg = xs();
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        op(0, 1, 8'h84, 32'h0, 0, 0);
        op(0, 1, 8'h74, cfg, 0, 0);
        wait_rdy;
        op(0, 1, 8'h84, 32'h1, 0, 0);
        op(1, 0, 8'h84, 32'h346, 0, 0);
        op(0, 0, 8'h0, 32'h0, 1, 0);
        chk("line", 1, line);
        repeat (25) @(posedge clk);
        chk("line", 1, line);
        energy_pending <= 1'b1;
        op(0, 0, 8'h0, 32'h0, 0, 1);
        op(0, 1, 8'h84, 32'h377, 0, 0);
        op(1, 0, 8'h84, 32'h376, 0, 0);
        op(0, 1, 8'h84, 32'h357, 0, 0);
        energy_pending <= 1'b0;
        op(1, 0, 8'h84, 32'h356, 0, 0);
        chk("line", 0, line);
        op(1, 0, 8'h84, 32'h30e, 0, 0);
        op(0, 0, 8'h0, 32'h0, 1, 0);
        chk("line", 0, line);
        repeat (25) @(posedge clk);
        chk("line", 1, line);
        op(1, 0, 8'h84, 32'h32c, 0, 0);
        op(0, 0, 8'h0, 32'h0, 1, 0);
        chk("line", 1, line);
        chk("irq", 1, irq);
        op(1, 0, 8'h84, 32'h32c, 1, 0);
        chk("irq", 1, irq);
        op(1, 0, 8'h84, 32'h32c, 0, 0);
        chk("irq", 0, irq);
        op(1, 0, 8'h84, 32'h130c, 0, 0);
        op(0, 1, 8'h84, 32'h130c, 0, 0);
        op(0, 0, 8'h0, 32'h0, 1, 0);
        op(1, 0, 8'h84, 32'h32c, 0, 0);
        chk("irq", 1, irq);
        op(1, 0, 8'h84, 32'h230c, 0, 0);
        op(0, 1, 8'h84, 32'h232c, 0, 0);
        op(0, 0, 8'h0, 32'h0, 0, 1);
        wait_rdy;
        op(0, 1, 8'h84, 32'h33d, 0, 0);
        for (int i = 0; i < 4; i++) op(0, 1, xs() | 8'h01, 32'h0, 0, 0);
        repeat (3) @(posedge clk);
        wrap_up;
    end
endmodule // wei_wake_ctrl_tb_top
